//--- rtl/cca_cfg.svh
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH

// register addresses in the special-function space
`define CCA_ADDR_CTRL1   8'ha1
`define CCA_ADDR_CTRL2   8'ha2
`define CCA_ADDR_CNT_HI  8'h9a
`define CCA_ADDR_CNT_LO  8'h9b
`define CCA_ADDR_CH0_CON 8'ha3
`define CCA_ADDR_CH1_CON 8'ha4
`define CCA_ADDR_CH2_CON 8'ha5
`define CCA_ADDR_CH3_CON 8'ha6
`define CCA_ADDR_CH4_CON 8'ha7
`define CCA_ADDR_CH0_DH  8'h9c
`define CCA_ADDR_CH0_DL  8'h9d
`define CCA_ADDR_CH1_DH  8'h9e
`define CCA_ADDR_CH1_DL  8'h9f
`define CCA_ADDR_CH2_DH  8'h91
`define CCA_ADDR_CH2_DL  8'h92
`define CCA_ADDR_CH3_DH  8'h93
`define CCA_ADDR_CH3_DL  8'h94
`define CCA_ADDR_CH4_DH  8'h95
`define CCA_ADDR_CH4_DL  8'h96

// field positions
`define CCA_BIT_RUN      7
`define CCA_BIT_IDLE     6
`define CCA_BIT_CLK_HI   7
`define CCA_BIT_CLK_LO   6
`define CCA_BIT_TOG      4
`define CCA_BIT_MODE_HI  2
`define CCA_BIT_CHAN_HI  4

// reset values and counts
`define CCA_CHANS        5
`define CCA_REG_RESET    8'h00
`define CCA_CNT_RESET    16'h0000
`define CCA_CNT_MAX      16'hffff
`define CCA_DIV_RESET    4'h0
`define CCA_DIV12_LAST   4'hb
`define CCA_DIV4_PHASE   2'h3

`endif

//--- rtl/cca_pkg.sv
package cca_pkg;

    typedef enum logic [2:0] {
        CCA_MODE_OFF   = 3'b000,
        CCA_MODE_POS   = 3'b001,
        CCA_MODE_NEG   = 3'b010,
        CCA_MODE_BOTH  = 3'b011,
        CCA_MODE_TIMER = 3'b100,
        CCA_MODE_HSO   = 3'b101,
        CCA_MODE_PWM8  = 3'b110,
        CCA_MODE_PWM16 = 3'b111
    } cca_mode_type;

    typedef enum logic [1:0] {
        CCA_CLK_SYS   = 2'b00,
        CCA_CLK_DIV4  = 2'b01,
        CCA_CLK_DIV12 = 2'b10,
        CCA_CLK_EXT   = 2'b11
    } cca_clk_sel_type;

endpackage : cca_pkg

//--- rtl/cca_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "cca_cfg.svh"

module cca_channel (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        con_wr,
    input  wire logic        dh_wr,
    input  wire logic        dl_wr,
    input  wire logic [7:0]  wr_data,
    input  wire logic [15:0] count_value,
    input  wire logic        count_adv,
    input  wire logic        count_roll,
    input  wire logic        counter_run,
    input  wire logic        chan_pin_in,
    output logic      [7:0]  con_value,
    output logic      [15:0] chan_data_value,
    output logic             chan_event,
    output logic             reload_req,
    output logic             chan_pin_out,
    output logic             chan_pin_oe
);
    import cca_pkg::*;

    cca_mode_type mode_ff;
    cca_mode_type nxt_mode;
    logic         tog_ff;
    logic         nxt_tog;
    logic [15:0]  data_ff;
    logic [15:0]  nxt_data;
    logic         pin_prev_ff;
    logic         pin_out_ff;
    logic         nxt_pin_out;
    logic         rise;
    logic         fall;
    logic         capture;
    logic         match;
    logic         timer_evt;
    logic         pwm8_hi;
    logic         pwm16_hi;

    always_comb begin
        rise      = chan_pin_in & ~pin_prev_ff;
        fall      = ~chan_pin_in & pin_prev_ff;
        capture   = ((mode_ff == CCA_MODE_POS) & rise) |
                    ((mode_ff == CCA_MODE_NEG) & fall) |
                    ((mode_ff == CCA_MODE_BOTH) & (rise | fall));
        match     = (mode_ff == CCA_MODE_HSO) & count_adv & (count_value == data_ff);
        timer_evt = (mode_ff == CCA_MODE_TIMER) & count_roll;
        chan_event = capture | match | timer_evt;
        // zero duty never satisfies the compare, so the pin stays low
        pwm8_hi   = count_value[7:0] < data_ff[7:0];
        pwm16_hi  = count_value < data_ff;

        nxt_mode = con_wr ? cca_mode_type'(wr_data[`CCA_BIT_MODE_HI:0]) : mode_ff;
        nxt_tog  = con_wr ? wr_data[`CCA_BIT_TOG] : tog_ff;
        if (match) begin
            nxt_tog = ~tog_ff;
        end

        nxt_data = data_ff;
        if (dh_wr) begin
            nxt_data[15:8] = wr_data;
        end
        if (dl_wr) begin
            nxt_data[7:0] = wr_data;
        end
        if (capture) begin
            nxt_data = count_value;
        end

        case (mode_ff)
            CCA_MODE_HSO:   nxt_pin_out = nxt_tog;
            CCA_MODE_PWM8:  nxt_pin_out = counter_run & pwm8_hi;
            CCA_MODE_PWM16: nxt_pin_out = counter_run & pwm16_hi;
            default:        nxt_pin_out = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_ff     <= CCA_MODE_OFF;
            tog_ff      <= 1'b0;
            data_ff     <= `CCA_CNT_RESET;
            pin_prev_ff <= 1'b0;
            pin_out_ff  <= 1'b0;
        end else begin
            mode_ff     <= nxt_mode;
            tog_ff      <= nxt_tog;
            data_ff     <= nxt_data;
            pin_prev_ff <= chan_pin_in;
            pin_out_ff  <= nxt_pin_out;
        end
    end

    always_comb begin
        con_value       = {3'b000, tog_ff, 1'b0, mode_ff};
        chan_data_value = data_ff;
        reload_req      = (mode_ff == CCA_MODE_TIMER);
        chan_pin_out    = pin_out_ff;
        chan_pin_oe     = (mode_ff == CCA_MODE_HSO) | (mode_ff == CCA_MODE_PWM8) |
                          (mode_ff == CCA_MODE_PWM16);
    end

endmodule : cca_channel
`default_nettype wire

//--- rtl/cca_regs.sv
// Overview of operation
// - counter advances only while counter_run is set; run resets to zero
// - idle_gate one stops the counter while the processor is idle
// - control one bits 4..0 enable each channel's interrupt
// - clock select 7:6: system, divide by four, by twelve, external falling edge
// - flags in control two set by events, cleared only by software writing zero
// - mode 000 off, 001 rising, 010 falling, 011 both-edge capture
// - mode 100 timer reload, 101 toggle output, 110 8-bit, 111 16-bit PWM
// - channel control holds toggle at bit 4 and mode at 2:0, reset 00h
// - capture copies the counter into the channel data on the chosen edge
// - timer mode reloads counter from channel data on rollover, sets flag
// - toggle output mode inverts toggle on match and drives it on the pin
// - PWM pin low while counter_run clear or duty is zero
`timescale 1ns/1ps
`default_nettype none
`include "cca_cfg.svh"

module cca_regs (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr_en,
    input  wire logic [7:0]  sfr_wr_data,
    output logic      [7:0]  sfr_rd_data,
    input  wire logic        cpu_idle,
    input  wire logic        external_count_input,
    input  wire logic [4:0]  chan_pin_in,
    output logic      [4:0]  chan_pin_out,
    output logic      [4:0]  chan_pin_oe,
    output logic             irq
);
    import cca_pkg::*;

    localparam int NCH = `CCA_CHANS;

    function automatic logic [7:0] con_addr(input int idx);
        case (idx)
            0:       con_addr = `CCA_ADDR_CH0_CON;
            1:       con_addr = `CCA_ADDR_CH1_CON;
            2:       con_addr = `CCA_ADDR_CH2_CON;
            3:       con_addr = `CCA_ADDR_CH3_CON;
            default: con_addr = `CCA_ADDR_CH4_CON;
        endcase
    endfunction : con_addr

    function automatic logic [7:0] dh_addr(input int idx);
        case (idx)
            0:       dh_addr = `CCA_ADDR_CH0_DH;
            1:       dh_addr = `CCA_ADDR_CH1_DH;
            2:       dh_addr = `CCA_ADDR_CH2_DH;
            3:       dh_addr = `CCA_ADDR_CH3_DH;
            default: dh_addr = `CCA_ADDR_CH4_DH;
        endcase
    endfunction : dh_addr

    function automatic logic [7:0] dl_addr(input int idx);
        case (idx)
            0:       dl_addr = `CCA_ADDR_CH0_DL;
            1:       dl_addr = `CCA_ADDR_CH1_DL;
            2:       dl_addr = `CCA_ADDR_CH2_DL;
            3:       dl_addr = `CCA_ADDR_CH3_DL;
            default: dl_addr = `CCA_ADDR_CH4_DL;
        endcase
    endfunction : dl_addr

    // control, counter and flag state
    logic            run_ff;
    logic            nxt_run;
    logic            idle_ff;
    logic            nxt_idle;
    logic [4:0]      ien_ff;
    logic [4:0]      nxt_ien;
    cca_clk_sel_type clk_sel_ff;
    cca_clk_sel_type nxt_clk_sel;
    logic [4:0]      flag_ff;
    logic [4:0]      nxt_flag;
    logic [15:0]     cnt_ff;
    logic [15:0]     nxt_cnt;
    logic [3:0]      div_ff;
    logic [3:0]      nxt_div;
    logic            ext_prev_ff;
    logic            adv_ff;
    logic            nxt_adv;
    logic            irq_ff;
    logic            nxt_irq;
    logic [7:0]      rd_data_ff;
    logic [7:0]      nxt_rd_data;

    // decode and per-channel results
    logic            wr_ctrl1;
    logic            wr_ctrl2;
    logic            wr_cnt_hi;
    logic            wr_cnt_lo;
    logic            count_en;
    logic            tick;
    logic            tick_en;
    logic            roll;
    logic            reload_hit;
    logic [15:0]     reload_val;
    logic [4:0]      con_wr;
    logic [4:0]      dh_wr;
    logic [4:0]      dl_wr;
    logic [4:0]      chan_event;
    logic [4:0]      reload_req;
    logic [7:0]      con_val [NCH];
    logic [15:0]     dat_val [NCH];

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_chan
            always_comb begin
                con_wr[gi] = sfr_wr_en & (sfr_addr == con_addr(gi));
                dh_wr[gi]  = sfr_wr_en & (sfr_addr == dh_addr(gi));
                dl_wr[gi]  = sfr_wr_en & (sfr_addr == dl_addr(gi));
            end

            cca_channel u_chan (
                .sys_clk         (sys_clk),
                .sys_rst         (sys_rst),
                .con_wr          (con_wr[gi]),
                .dh_wr           (dh_wr[gi]),
                .dl_wr           (dl_wr[gi]),
                .wr_data         (sfr_wr_data),
                .count_value     (cnt_ff),
                .count_adv       (adv_ff),
                .count_roll      (roll),
                .counter_run     (run_ff),
                .chan_pin_in     (chan_pin_in[gi]),
                .con_value       (con_val[gi]),
                .chan_data_value (dat_val[gi]),
                .chan_event      (chan_event[gi]),
                .reload_req      (reload_req[gi]),
                .chan_pin_out    (chan_pin_out[gi]),
                .chan_pin_oe     (chan_pin_oe[gi])
            );
        end
    endgenerate

    // register writes and control fields
    always_comb begin
        wr_ctrl1  = sfr_wr_en & (sfr_addr == `CCA_ADDR_CTRL1);
        wr_ctrl2  = sfr_wr_en & (sfr_addr == `CCA_ADDR_CTRL2);
        wr_cnt_hi = sfr_wr_en & (sfr_addr == `CCA_ADDR_CNT_HI);
        wr_cnt_lo = sfr_wr_en & (sfr_addr == `CCA_ADDR_CNT_LO);

        nxt_run     = wr_ctrl1 ? sfr_wr_data[`CCA_BIT_RUN] : run_ff;
        nxt_idle    = wr_ctrl1 ? sfr_wr_data[`CCA_BIT_IDLE] : idle_ff;
        nxt_ien     = wr_ctrl1 ? sfr_wr_data[`CCA_BIT_CHAN_HI:0] : ien_ff;
        nxt_clk_sel = wr_ctrl2 ?
                      cca_clk_sel_type'(sfr_wr_data[`CCA_BIT_CLK_HI:`CCA_BIT_CLK_LO]) :
                      clk_sel_ff;
        // a hardware event in the same cycle as a software clear still sets
        nxt_flag    = (wr_ctrl2 ? sfr_wr_data[`CCA_BIT_CHAN_HI:0] : flag_ff) | chan_event;
        nxt_irq     = |(nxt_flag & nxt_ien);
    end

    // counter tick source and prescaler
    always_comb begin
        count_en = run_ff & ~(idle_ff & cpu_idle);
        case (clk_sel_ff)
            CCA_CLK_SYS:   tick = 1'b1;
            CCA_CLK_DIV4:  tick = (div_ff[1:0] == `CCA_DIV4_PHASE);
            CCA_CLK_DIV12: tick = (div_ff == `CCA_DIV12_LAST);
            CCA_CLK_EXT:   tick = ext_prev_ff & ~external_count_input;
            default:       tick = 1'b0;
        endcase
        tick_en = count_en & tick;
        roll    = tick_en & (cnt_ff == `CCA_CNT_MAX);

        if (!count_en) begin
            nxt_div = div_ff;
        end else if (div_ff == `CCA_DIV12_LAST) begin
            nxt_div = `CCA_DIV_RESET;
        end else begin
            nxt_div = div_ff + 4'h1;
        end
    end

    // lowest-numbered timer channel supplies the reload value
    always_comb begin
        reload_hit = 1'b0;
        reload_val = `CCA_CNT_RESET;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (reload_req[i]) begin
                reload_hit = 1'b1;
                reload_val = dat_val[i];
            end
        end
    end

    always_comb begin
        nxt_cnt = cnt_ff;
        if (roll & reload_hit) begin
            nxt_cnt = reload_val;
        end else if (tick_en) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
        // software writes take priority over counting
        if (wr_cnt_hi) begin
            nxt_cnt[15:8] = sfr_wr_data;
        end
        if (wr_cnt_lo) begin
            nxt_cnt[7:0] = sfr_wr_data;
        end
        nxt_adv = tick_en;
    end

    // read data, registered one cycle after the address
    always_comb begin
        nxt_rd_data = `CCA_REG_RESET;
        case (sfr_addr)
            `CCA_ADDR_CTRL1:  nxt_rd_data = {run_ff, idle_ff, 1'b0, ien_ff};
            `CCA_ADDR_CTRL2:  nxt_rd_data = {clk_sel_ff, 1'b0, flag_ff};
            `CCA_ADDR_CNT_HI: nxt_rd_data = cnt_ff[15:8];
            `CCA_ADDR_CNT_LO: nxt_rd_data = cnt_ff[7:0];
            default:          nxt_rd_data = `CCA_REG_RESET;
        endcase
        for (int i = 0; i < NCH; i++) begin
            if (sfr_addr == con_addr(i)) begin
                nxt_rd_data = con_val[i];
            end
            if (sfr_addr == dh_addr(i)) begin
                nxt_rd_data = dat_val[i][15:8];
            end
            if (sfr_addr == dl_addr(i)) begin
                nxt_rd_data = dat_val[i][7:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            run_ff      <= 1'b0;
            idle_ff     <= 1'b0;
            ien_ff      <= 5'h00;
            clk_sel_ff  <= CCA_CLK_SYS;
            flag_ff     <= 5'h00;
            cnt_ff      <= `CCA_CNT_RESET;
            div_ff      <= `CCA_DIV_RESET;
            ext_prev_ff <= 1'b0;
            adv_ff      <= 1'b0;
            irq_ff      <= 1'b0;
            rd_data_ff  <= `CCA_REG_RESET;
        end else begin
            run_ff      <= nxt_run;
            idle_ff     <= nxt_idle;
            ien_ff      <= nxt_ien;
            clk_sel_ff  <= nxt_clk_sel;
            flag_ff     <= nxt_flag;
            cnt_ff      <= nxt_cnt;
            div_ff      <= nxt_div;
            ext_prev_ff <= external_count_input;
            adv_ff      <= nxt_adv;
            irq_ff      <= nxt_irq;
            rd_data_ff  <= nxt_rd_data;
        end
    end

    always_comb begin
        sfr_rd_data = rd_data_ff;
        irq         = irq_ff;
    end

endmodule : cca_regs
`default_nettype wire

//--- testbench/cca_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cca_regs_sva (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr_en,
    input wire logic [7:0] sfr_wr_data,
    input wire logic [7:0] sfr_rd_data,
    input wire logic       cpu_idle,
    input wire logic       external_count_input,
    input wire logic [4:0] chan_pin_in,
    input wire logic [4:0] chan_pin_out,
    input wire logic [4:0] chan_pin_oe,
    input wire logic       irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // shadows of control writes, seen from the register port alone
    logic [7:0] ctl1_ff;
    logic [1:0] csel_ff;
    logic [2:0] mode_ff [5];
    logic [4:0] exp_oe;
    logic [4:0] pwm_mask;
    logic       cnt_rd;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctl1_ff <= 8'h00;
            csel_ff <= 2'h0;
            for (int i = 0; i < 5; i++)
                mode_ff[i] <= 3'h0;
        end else if (sfr_wr_en) begin
            if (sfr_addr == 8'ha1)
                ctl1_ff <= sfr_wr_data;
            if (sfr_addr == 8'ha2)
                csel_ff <= sfr_wr_data[7:6];
            for (int i = 0; i < 5; i++)
                if (sfr_addr == 8'(32'ha3 + i))
                    mode_ff[i] <= sfr_wr_data[2:0];
        end
    end
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            exp_oe[i]   = mode_ff[i] >= 3'h5;
            pwm_mask[i] = mode_ff[i][2:1] == 2'h3;
        end
    end
    assign cnt_rd = sfr_addr == 8'h9b && !sfr_wr_en;
    reset_clear_a: assert property ($fell(sys_rst) |->
        sfr_rd_data == 8'h00 && irq == 1'b0 && chan_pin_oe == 5'h00)
        else $error("outputs not clear after reset");
    ctrl_unused_a: assert property (sfr_addr inside {8'ha1, 8'ha2} |=> !sfr_rd_data[5])
        else $error("unused control bit reads one");
    chan_unused_a: assert property (sfr_addr inside {[8'ha3:8'ha7]} |=>
        (sfr_rd_data & 8'he8) == 8'h00) else $error("unused channel bits read one");
    ctrl1_back_a: assert property (sfr_wr_en && sfr_addr == 8'ha1 ##1
        !sfr_wr_en && sfr_addr == 8'ha1 |=> sfr_rd_data == ($past(sfr_wr_data, 2) & 8'hdf))
        else $error("control one readback wrong");
    oe_decode_a: assert property (chan_pin_oe == exp_oe)
        else $error("pin enable does not follow mode");
    pwm_stop_a: assert property (!ctl1_ff[7] && $past(ctl1_ff[7]) == 1'b0 && $stable(pwm_mask)
        |-> (chan_pin_out & pwm_mask) == 5'h00) else $error("pwm pin high while stopped");
    irq_cause_a: assert property ($rose(irq) |-> ctl1_ff[4:0] != 5'h00)
        else $error("irq rose with no enable");
    irq_mask_a: assert property (sfr_wr_en && sfr_addr == 8'ha1 && sfr_wr_data[4:0] == 5'h00
        |=> !irq) else $error("irq high with all enables clear");
    count_hold_a: assert property (cnt_rd && (!ctl1_ff[7] || ctl1_ff[6] && cpu_idle)
        ##1 cnt_rd |=> $stable(sfr_rd_data)) else $error("counter moved while stopped");
    count_step_a: assert property (cnt_rd && ctl1_ff[7] && !(ctl1_ff[6] && cpu_idle)
        && csel_ff == 2'h0 ##1 cnt_rd
        |=> sfr_rd_data == $past(sfr_rd_data) + 8'h01 || $past(sfr_rd_data) == 8'hff)
        else $error("counter did not step each clock");
    pwm_high_c: cover property ((chan_pin_out & pwm_mask) != 5'h00);
    irq_seen_c: cover property ($rose(irq));
    count_run_c: cover property (cnt_rd && ctl1_ff[7] ##1 cnt_rd);
endmodule : cca_regs_sva
`default_nettype wire

//--- testbench/cca_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model (
    input wire logic [4:0] stim_level,
    input wire logic [4:0] chan_pin_out,
    input wire logic [4:0] chan_pin_oe,
    output logic     [4:0] chan_pin_in
);
    // a driven pin reads back its own level, an undriven one follows the external source
    always_comb begin
        for (int i = 0; i < 5; i++)
            chan_pin_in[i] = chan_pin_oe[i] ? chan_pin_out[i] : stim_level[i];
    end
endmodule : cca_pin_model
`default_nettype wire

//--- testbench/cca_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module cca_regs_test;
    logic sys_clk, sys_rst, sfr_wr_en, cpu_idle, external_count_input, irq;
    logic [7:0] sfr_addr, sfr_wr_data, sfr_rd_data, got, d, m;
    logic [4:0] chan_pin_in, chan_pin_out, chan_pin_oe, stim_level;
    logic [1:0] ext_div;
    logic [15:0] v1, v2;
    logic [31:0] hi;
    int bad_count, checked, n;
    logic [7:0] addr_tab [19] = '{8'ha1, 8'ha2, 8'h9a, 8'h9b, 8'ha3, 8'ha4, 8'ha5, 8'ha6,
        8'ha7, 8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96};
    cca_regs cca_regs_inst (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr_en, .sfr_wr_data,
        .sfr_rd_data, .cpu_idle, .external_count_input, .chan_pin_in, .chan_pin_out,
        .chan_pin_oe, .irq);
    cca_pin_model cca_pin_model_inst (.stim_level, .chan_pin_out, .chan_pin_oe, .chan_pin_in);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // external count source: one falling edge every four clocks
    always @(posedge sys_clk) begin
        #1;
        ext_div = ext_div + 2'h1;
        external_count_input = ext_div[1];
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_wr_data = dv;
        sfr_wr_en = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_wr_en = 1'b0;
    endtask : wr
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        @(posedge sys_clk);
        #1;
        got = sfr_rd_data;
        chk(got, e);
    endtask : chk_reg
    task automatic set_cnt(input logic [15:0] v);
        wr(8'h9a, v[15:8]);
        wr(8'h9b, v[7:0]);
    endtask : set_cnt
    // run the counter for exactly k plus two clocks, reading the low byte meanwhile
    task automatic run_for(input logic [7:0] c1, input int k);
        wr(8'ha1, c1);
        sfr_addr = 8'h9b;
        repeat (k) @(posedge sys_clk);
        wr(8'ha1, 8'h00);
    endtask : run_for
    task automatic run_count(input logic [7:0] c1, input logic [1:0] sel, input logic idle,
                             input logic [7:0] e);
        set_cnt(16'h0000);
        wr(8'ha2, {sel, 6'h00});
        cpu_idle = idle;
        run_for(c1, 46);
        cpu_idle = 1'b0;
        chk_reg(8'h9b, e);
    endtask : run_count
    initial begin
        #1900000;
        bad_count++;
        test_done();
    end
    initial begin
        {sys_rst, sfr_addr, sfr_wr_en, sfr_wr_data, cpu_idle} = {1'b1, 18'h0};
        {stim_level, ext_div, external_count_input, bad_count, checked} = '0;
        void'($urandom(32'hed731179));
        repeat (20) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        foreach (addr_tab[i]) chk_reg(addr_tab[i], 8'h00);
        chk_reg(8'h80, 8'h00);
        $display("test reset done");
        repeat (3) begin
            foreach (addr_tab[i]) begin
                d = 8'($urandom);
                m = i == 0 ? 8'h5f : i == 1 ? 8'hdf : (i > 3 && i < 9) ? 8'h17 : 8'hff;
                wr(addr_tab[i], d & (i == 0 ? 8'h7f : 8'hff));
                chk_reg(addr_tab[i], d & m);
            end
        end
        for (int i = 2; i < 9; i++) wr(addr_tab[i], 8'h00);
        wr(8'ha2, 8'h00);
        wr(8'ha1, 8'h00);
        for (int md = 0; md < 8; md++) begin
            wr(addr_tab[4], 8'(md));
            chk(chan_pin_oe[0], md > 4);
        end
        wr(addr_tab[4], 8'h00);
        $display("test registers done");
        run_count(8'h80, 2'h0, 1'b0, 8'h30);
        run_count(8'h80, 2'h1, 1'b0, 8'h0c);
        run_count(8'h80, 2'h2, 1'b0, 8'h04);
        run_count(8'h80, 2'h3, 1'b0, 8'h0c);
        run_count(8'hc0, 2'h0, 1'b1, 8'h00);
        run_count(8'h80, 2'h0, 1'b1, 8'h30);
        run_count(8'h00, 2'h0, 1'b0, 8'h00);
        wr(8'ha2, 8'h00);
        $display("test counting done");
        for (int md = 0; md < 4; md++) begin
            n = $urandom_range(4, 0);
            v1 = 16'($urandom);
            v2 = 16'($urandom);
            wr(addr_tab[9 + 2 * n], 8'h00);
            wr(addr_tab[10 + 2 * n], 8'h00);
            set_cnt(v1);
            wr(addr_tab[4 + n], 8'(md));
            stim_level[n] = 1'b1;
            set_cnt(v2);
            stim_level[n] = 1'b0;
            set_cnt(v2 ^ 16'h5a5a);
            v1 = md == 0 ? 16'h0000 : md == 1 ? v1 : v2;
            chk_reg(addr_tab[9 + 2 * n], v1[15:8]);
            chk_reg(addr_tab[10 + 2 * n], v1[7:0]);
            chk_reg(8'ha2, md == 0 ? 8'h00 : 8'(1 << n));
            wr(8'ha1, 8'(1 << n));
            chk(irq, md != 0);
            wr(8'ha1, 8'h00);
            chk(irq, 1'b0);
            wr(8'ha2, 8'h00);
            chk_reg(8'ha2, 8'h00);
            wr(addr_tab[4 + n], 8'h00);
        end
        $display("test capture done");
        n = $urandom_range(4, 0);
        v1 = 16'($urandom_range(32'hfff0, 0));
        wr(addr_tab[9 + 2 * n], v1[15:8]);
        wr(addr_tab[10 + 2 * n], v1[7:0]);
        wr(addr_tab[4 + n], 8'h04);
        set_cnt(16'hfffe);
        run_for(8'h80, 2);
        v2 = v1 + 16'h0002;
        chk_reg(8'h9a, v2[15:8]);
        chk_reg(8'h9b, v2[7:0]);
        chk_reg(8'ha2, 8'(1 << n));
        wr(addr_tab[4 + n], 8'h00);
        $display("test reload done");
        n = $urandom_range(4, 0);
        v1 = 16'($urandom_range(32'hff00, 0));
        v2 = v1 + 16'h0003;
        wr(addr_tab[9 + 2 * n], v2[15:8]);
        wr(addr_tab[10 + 2 * n], v2[7:0]);
        for (int p = 0; p < 2; p++) begin
            set_cnt(v1);
            wr(addr_tab[4 + n], p == 0 ? 8'h05 : 8'h15);
            run_for(8'h80, 8);
            chk_reg(addr_tab[4 + n], p == 0 ? 8'h15 : 8'h05);
            chk(chan_pin_out, p == 0 ? 5'(1 << n) : 5'h00);
        end
        wr(addr_tab[4 + n], 8'h00);
        wr(8'ha2, 8'h00);
        $display("test toggle done");
        for (int p = 0; p < 3; p++) begin
            n = $urandom_range(4, 0);
            v1 = p == 0 ? {8'($urandom), 8'h00} : 16'($urandom);
            wr(addr_tab[9 + 2 * n], v1[15:8]);
            wr(addr_tab[10 + 2 * n], v1[7:0]);
            wr(addr_tab[4 + n], p == 2 ? 8'h07 : 8'h06);
            wr(8'ha1, 8'h80);
            repeat (4) @(posedge sys_clk);
            hi = 32'h0;
            repeat (p == 2 ? 65536 : 256) begin
                @(posedge sys_clk);
                #1;
                hi = hi + chan_pin_out[n];
            end
            chk(hi, p == 2 ? v1 : v1[7:0]);
            wr(8'ha1, 8'h00);
            repeat (2) @(posedge sys_clk);
            chk(chan_pin_out[n], 1'b0);
            wr(addr_tab[4 + n], 8'h00);
        end
        $display("test pwm done");
        test_done();
    end
endmodule : cca_regs_test
bind cca_regs cca_regs_sva cca_regs_sva_inst (.sys_clk, .sys_rst, .sfr_addr, .sfr_wr_en,
    .sfr_wr_data, .sfr_rd_data, .cpu_idle, .external_count_input, .chan_pin_in,
    .chan_pin_out, .chan_pin_oe, .irq);
`default_nettype wire
